// ---- hdl/dsc_pkg.sv ----
`default_nettype none
package dsc_pkg;
    // =========================================
    // register word indices, byte address is index times four
    localparam logic [13:0] IDX_P1_SEL = 14'h009C;
    localparam logic [13:0] IDX_P2_SEL = 14'h009D;
    localparam logic [13:0] IDX_P3_SEL = 14'h009E;
    localparam logic [13:0] IDX_CTRL = 14'h00AB;
    localparam logic [13:0] IDX_PSC = 14'h00AC;
    localparam logic [13:0] IDX_EXT = 14'h00AD;
    localparam logic [13:0] IDX_MISC_SEL = 14'h00B6;
    localparam logic [13:0] IDX_STATUS = 14'h00B8;
    localparam logic [13:0] IDX_RAM_FIRST = 14'h0500;
    localparam logic [13:0] IDX_RAM_LAST = 14'h051B;
    localparam int RAM_BYTES = 28;
    localparam logic [7:0] REG_RESET = 8'h00;
    // =========================================
    // field positions
    localparam int CTRL_TYPE_BIT = 7;
    localparam int CTRL_ON_BIT = 6;
    localparam int CTRL_DUTY_CODE_LOW_BIT = 4;
    localparam int EXT_RELEASE_BIT = 7;
    localparam int EXT_DUTY2_BIT = 6;
    localparam int EXT_DUTY1_BIT = 5;
    localparam logic [7:0] PSC_MASK = 8'h03;
    localparam logic [3:0] OSC_SLOW_A = 4'hA;
    localparam logic [3:0] OSC_SLOW_B = 4'hB;
    localparam logic [3:0] OSC_SLOW_C = 4'hD;
    // =========================================
    // timing
    localparam int CLK_HZ = 100000000;
    localparam int SRC_FAST_HZ = 128000;
    localparam int SRC_SLOW_HZ = 32768;
    localparam int FRAME_SLOW_HZ = 64;
    localparam int FRAME_FAST_HZ = 256;
    localparam int FAST_DIV = CLK_HZ / SRC_FAST_HZ;
    localparam int SLOW_DIV = CLK_HZ / SRC_SLOW_HZ;
    localparam logic [9:0] FRAME_TICKS_SLOW = 10'(SRC_SLOW_HZ / FRAME_SLOW_HZ);
    localparam logic [9:0] FRAME_TICKS_FAST = 10'(SRC_FAST_HZ / FRAME_FAST_HZ);
    localparam logic [2:0] PSC_MAX = 3'h4;
    // =========================================
    typedef enum logic [1:0] {
        SC_IDLE = 2'b00,
        SC_RUN = 2'b01,
        SC_HOLD = 2'b10
    } dsc_scan_t;
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] val;
    } dsc_pin8_t;
    // =========================================
    function automatic logic [3:0] led_duty(input logic [2:0] code);
        case (code)
            3'h1: led_duty = 4'h8;
            3'h2: led_duty = 4'h3;
            3'h3: led_duty = 4'h5;
            3'h4: led_duty = 4'h6;
            3'h5: led_duty = 4'h7;
            default: led_duty = 4'h4;
        endcase
    endfunction
    function automatic logic [3:0] lcd_duty(input logic [2:0] code);
        case (code)
            3'h1: lcd_duty = 4'h8;
            3'h3: lcd_duty = 4'h5;
            3'h4, 3'h5: lcd_duty = 4'h6;
            default: lcd_duty = 4'h4;
        endcase
    endfunction
    function automatic logic [4:0] lcd_segs(input logic [2:0] code);
        case (code)
            3'h1: lcd_segs = 5'h18;
            3'h3: lcd_segs = 5'h1B;
            3'h4, 3'h5: lcd_segs = 5'h1A;
            default: lcd_segs = 5'h1C;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- hdl/dsc_display_scan.sv ----
`default_nettype none
module dsc_display_scan (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [15:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [3:0] oscillator_option_code,
    input wire logic scan_hold_option,
    output dsc_pkg::dsc_pin8_t led_segment_output,
    output dsc_pkg::dsc_pin8_t led_common_output,
    output logic [7:0] lcd_common_output,
    output logic [7:0] lcd_common_oe,
    output logic [27:0] lcd_segment_output,
    output logic [27:0] lcd_segment_oe
);

    // =========================================
    // registers
    logic [7:0] p1_reg;
    logic [7:0] p2_reg;
    logic [7:0] p3_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] psc_reg;
    logic [7:0] ext_reg;
    logic [7:0] misc_reg;
    logic [7:0] ram_reg [0:dsc_pkg::RAM_BYTES-1];
    logic ack_reg;
    logic [31:0] rdat_reg;

    // =========================================
    // bus decode
    logic req;
    logic [13:0] widx;
    logic wr;
    logic rd_take;
    logic ram_hit;
    logic [13:0] ram_off;
    logic [4:0] ram_sel;
    logic [7:0] stat_byte;
    logic [7:0] rd_byte;

    assign req = wb_cyc & wb_stb;
    assign widx = wb_adr[15:2];
    // commit on the edge where the master sees ack
    assign wr = req & wb_we & ack_reg & wb_sel[0];
    assign rd_take = req & ~ack_reg;
    assign ram_hit = (widx >= dsc_pkg::IDX_RAM_FIRST) && (widx <= dsc_pkg::IDX_RAM_LAST);
    assign ram_off = widx - dsc_pkg::IDX_RAM_FIRST;
    assign ram_sel = ram_off[4:0];

    assign rd_byte = ram_hit ? ram_reg[ram_sel] :
        (widx == dsc_pkg::IDX_P1_SEL) ? p1_reg :
        (widx == dsc_pkg::IDX_P2_SEL) ? p2_reg :
        (widx == dsc_pkg::IDX_P3_SEL) ? p3_reg :
        (widx == dsc_pkg::IDX_CTRL) ? ctrl_reg :
        (widx == dsc_pkg::IDX_PSC) ? psc_reg :
        (widx == dsc_pkg::IDX_EXT) ? ext_reg :
        (widx == dsc_pkg::IDX_MISC_SEL) ? misc_reg :
        (widx == dsc_pkg::IDX_STATUS) ? stat_byte : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= rd_take;
            if (rd_take) begin
                rdat_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            p1_reg <= dsc_pkg::REG_RESET;
            p2_reg <= dsc_pkg::REG_RESET;
            p3_reg <= dsc_pkg::REG_RESET;
            ctrl_reg <= dsc_pkg::REG_RESET;
            psc_reg <= dsc_pkg::REG_RESET;
            ext_reg <= dsc_pkg::REG_RESET;
            misc_reg <= dsc_pkg::REG_RESET;
        end else if (wr) begin
            case (widx)
                dsc_pkg::IDX_P1_SEL: p1_reg <= wb_dat_w[7:0];
                dsc_pkg::IDX_P2_SEL: p2_reg <= wb_dat_w[7:0];
                dsc_pkg::IDX_P3_SEL: p3_reg <= wb_dat_w[7:0];
                dsc_pkg::IDX_CTRL: ctrl_reg <= wb_dat_w[7:0];
                dsc_pkg::IDX_PSC: psc_reg <= wb_dat_w[7:0] & dsc_pkg::PSC_MASK;
                dsc_pkg::IDX_EXT: ext_reg <= wb_dat_w[7:0];
                dsc_pkg::IDX_MISC_SEL: misc_reg <= wb_dat_w[7:0];
                default: ;
            endcase
        end
    end

    assign wb_ack = ack_reg;
    assign wb_dat_r = rdat_reg;

    // =========================================
    // option inputs come from pads, two stages first
    logic [3:0] osc_s1_reg;
    logic [3:0] osc_reg;
    logic hold_s1_reg;
    logic hold_opt_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_s1_reg <= 4'h0;
            osc_reg <= 4'h0;
            hold_s1_reg <= 1'b0;
            hold_opt_reg <= 1'b0;
        end else begin
            osc_s1_reg <= oscillator_option_code;
            osc_reg <= osc_s1_reg;
            hold_s1_reg <= scan_hold_option;
            hold_opt_reg <= hold_s1_reg;
        end
    end

    // =========================================
    // control fields
    logic type_led;
    logic drv_on;
    logic pins_release;
    logic [2:0] duty_code;
    logic led_active;
    logic lcd_active;
    logic [3:0] duty_n;
    logic [4:0] seg_n;

    assign type_led = ctrl_reg[dsc_pkg::CTRL_TYPE_BIT];
    assign drv_on = ctrl_reg[dsc_pkg::CTRL_ON_BIT];
    assign pins_release = ext_reg[dsc_pkg::EXT_RELEASE_BIT];
    assign duty_code = {ext_reg[dsc_pkg::EXT_DUTY2_BIT], ext_reg[dsc_pkg::EXT_DUTY1_BIT],
        ctrl_reg[dsc_pkg::CTRL_DUTY_CODE_LOW_BIT]};
    // the two drivers share one enable, the type bit picks one
    assign led_active = type_led & drv_on;
    assign lcd_active = ~type_led & drv_on;
    assign duty_n = type_led ? dsc_pkg::led_duty(duty_code) : dsc_pkg::lcd_duty(duty_code);
    assign seg_n = dsc_pkg::lcd_segs(duty_code);

    // =========================================
    // display clock: rates are enables from the system clock
    logic [9:0] fast_cnt_reg;
    logic [11:0] slow_cnt_reg;
    logic [1:0] psc_cnt_reg;
    logic fast_tick;
    logic slow_tick;
    logic slow_sel;
    logic [2:0] psc_div;
    logic psc_tick;
    logic disp_tick;
    logic [9:0] frame_ticks;
    logic [9:0] slot_len;

    assign fast_tick = fast_cnt_reg == 10'(dsc_pkg::FAST_DIV - 1);
    assign slow_tick = slow_cnt_reg == 12'(dsc_pkg::SLOW_DIV - 1);
    assign slow_sel = (osc_reg == dsc_pkg::OSC_SLOW_A) || (osc_reg == dsc_pkg::OSC_SLOW_B) ||
        (osc_reg == dsc_pkg::OSC_SLOW_C);
    assign psc_div = dsc_pkg::PSC_MAX - {1'b0, psc_reg[1:0]};
    assign psc_tick = fast_tick && ({1'b0, psc_cnt_reg} == psc_div - 3'h1);
    assign disp_tick = slow_sel ? slow_tick : psc_tick;
    assign frame_ticks = slow_sel ? dsc_pkg::FRAME_TICKS_SLOW : dsc_pkg::FRAME_TICKS_FAST;
    // integer share, the frame loses the remainder ticks
    assign slot_len = 10'(frame_ticks / {6'h00, duty_n});

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fast_cnt_reg <= 10'h000;
            slow_cnt_reg <= 12'h000;
            psc_cnt_reg <= 2'h0;
        end else begin
            fast_cnt_reg <= fast_tick ? 10'h000 : fast_cnt_reg + 10'h001;
            slow_cnt_reg <= slow_tick ? 12'h000 : slow_cnt_reg + 12'h001;
            if (fast_tick) begin
                psc_cnt_reg <= psc_tick ? 2'h0 : psc_cnt_reg + 2'h1;
            end
        end
    end

    // =========================================
    // scan sequencer
    dsc_pkg::dsc_scan_t state_reg;
    dsc_pkg::dsc_scan_t state_next;
    logic [2:0] com_idx_reg;
    logic [9:0] slot_cnt_reg;
    logic slot_end;
    logic com_last;

    assign state_next = ~(led_active | lcd_active) ? dsc_pkg::SC_IDLE :
        (pins_release & hold_opt_reg) ? dsc_pkg::SC_HOLD : dsc_pkg::SC_RUN;
    assign slot_end = slot_cnt_reg >= slot_len - 10'h001;
    assign com_last = {1'b0, com_idx_reg} >= duty_n - 4'h1;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= dsc_pkg::SC_IDLE;
            com_idx_reg <= 3'h0;
            slot_cnt_reg <= 10'h000;
        end else begin
            state_reg <= state_next;
            case (state_reg)
                dsc_pkg::SC_IDLE: begin
                    com_idx_reg <= 3'h0;
                    slot_cnt_reg <= 10'h000;
                end
                dsc_pkg::SC_RUN: begin
                    if ({1'b0, com_idx_reg} >= duty_n) begin
                        com_idx_reg <= 3'h0;
                        slot_cnt_reg <= 10'h000;
                    end else if (disp_tick && slot_end) begin
                        slot_cnt_reg <= 10'h000;
                        com_idx_reg <= com_last ? 3'h0 : com_idx_reg + 3'h1;
                    end else if (disp_tick) begin
                        slot_cnt_reg <= slot_cnt_reg + 10'h001;
                    end
                end
                dsc_pkg::SC_HOLD: ;
                default: begin
                    com_idx_reg <= 3'h0;
                    slot_cnt_reg <= 10'h000;
                end
            endcase
        end
    end

    assign stat_byte = {1'b0, state_reg == dsc_pkg::SC_HOLD, lcd_active, led_active,
        1'b0, com_idx_reg};

    // =========================================
    // pin data
    logic led_pins;
    logic lcd_pins;
    logic [7:0] com_onehot;
    logic [7:0] led_byte;
    logic [27:0] seg_own;
    logic [27:0] lcd_seg_next;
    logic [27:0] lcd_oe_next;

    assign led_pins = led_active & ~pins_release;
    assign lcd_pins = lcd_active & ~pins_release;
    assign com_onehot = 8'h01 << com_idx_reg;
    assign led_byte = ram_reg[com_idx_reg];
    // glass pin ownership only; led mode never looks at these
    assign seg_own = {4'hF, misc_reg, p2_reg, p1_reg};

    genvar gi;
    generate
        for (gi = 0; gi < dsc_pkg::RAM_BYTES; gi++) begin : g_entry
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    ram_reg[gi] <= 8'h00;
                end else if (wr && ram_hit && ram_sel == 5'(gi)) begin
                    ram_reg[gi] <= wb_dat_w[7:0];
                end
            end
            // com index stays below duty, so unused high bits stay unread
            assign lcd_seg_next[gi] = lcd_active && (5'(gi) < seg_n) &&
                ram_reg[gi][com_idx_reg];
            assign lcd_oe_next[gi] = lcd_pins && seg_own[gi] && (5'(gi) < seg_n);
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            led_segment_output <= '0;
            led_common_output <= '0;
            lcd_common_output <= 8'h00;
            lcd_common_oe <= 8'h00;
            lcd_segment_output <= 28'h000_0000;
            lcd_segment_oe <= 28'h000_0000;
        end else begin
            led_segment_output.val <= led_active ? led_byte : 8'h00;
            led_segment_output.oe <= led_pins ? p1_reg : 8'h00;
            led_common_output.val <= led_active ? com_onehot : 8'h00;
            led_common_output.oe <= led_pins ? p3_reg : 8'h00;
            lcd_common_output <= lcd_active ? com_onehot : 8'h00;
            lcd_common_oe <= lcd_pins ? 8'hFF : 8'h00;
            lcd_segment_output <= lcd_seg_next;
            lcd_segment_oe <= lcd_oe_next;
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_one_driver_only: assert property (
        !((|led_common_output.val) && (|lcd_common_output)))
        else $error("led and glass commons active together");

    chk_reset_led_off: assert property (
        $fell(sys_rst) |-> (led_common_output == '0) && (led_segment_output == '0))
        else $error("led pins not off after reset");

    chk_off_bit_stops: assert property (
        !drv_on |=> (led_common_output.val == 8'h00) && (state_reg != dsc_pkg::SC_RUN))
        else $error("led driver runs with on bit clear");

    chk_common_onehot: assert property (
        $onehot0(led_common_output.val))
        else $error("more than one led common active");

    chk_duty_third: assert property (
        (led_active && duty_code == 3'h2 && state_reg == dsc_pkg::SC_RUN) [*3]
        |-> com_idx_reg <= 3'h2)
        else $error("1/3 duty scans beyond third common");

    chk_hold_freeze: assert property (
        (state_reg == dsc_pkg::SC_HOLD) [*2] |-> $stable(com_idx_reg) && $stable(slot_cnt_reg))
        else $error("scan moved while held");

    chk_release_io: assert property (
        pins_release |=> (led_segment_output.oe == 8'h00) && (led_common_output.oe == 8'h00)
        && (lcd_segment_oe == 28'h000_0000))
        else $error("display pin driven while released");

    chk_seg_select: assert property (
        led_pins |=> led_segment_output.oe == $past(p1_reg))
        else $error("segment enables do not follow port 1 select");

    chk_com_select: assert property (
        led_pins |=> led_common_output.oe == $past(p3_reg))
        else $error("common enables do not follow port 3 select");

    chk_led_pattern: assert property (
        led_active |=> led_segment_output.val == $past(led_byte))
        else $error("segments not from the active common byte");

    chk_misc_ignored: assert property (
        led_active |=> lcd_segment_oe == 28'h000_0000)
        else $error("glass selects act in led mode");

    chk_glass_unused: assert property (
        lcd_active && duty_code == 3'h1 |=> lcd_segment_output[27:24] == 4'h0)
        else $error("unused glass segment driven");

    chk_slow_source: assert property (
        slow_sel && disp_tick |-> slow_tick)
        else $error("slow source not used");

    chk_prescale_div: assert property (
        !slow_sel && psc_reg[1:0] == 2'h3 && fast_tick |-> disp_tick)
        else $error("prescale 1/1 skips a tick");

    cov_led_run: cover property (led_active && disp_tick && slot_end && com_last);
    cov_lcd_run: cover property (lcd_active && state_reg == dsc_pkg::SC_RUN && disp_tick);
    cov_hold: cover property (state_reg == dsc_pkg::SC_HOLD ##1 state_reg == dsc_pkg::SC_RUN);
    cov_slow: cover property (led_active && slow_sel && disp_tick);

endmodule
`default_nettype wire

// ---- testbench/dsc_led_matrix.sv ----
`default_nettype none
module dsc_led_matrix (
    input wire logic ref_clk,
    input wire dsc_pkg::dsc_pin8_t seg_pins,
    input wire dsc_pkg::dsc_pin8_t com_pins,
    output logic [7:0] lit_row,
    output logic [3:0] lit_com,
    output logic [7:0] overlap_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================
    // matrix view of the pins
    // released pins count as dark: the matrix has no pull-ups
    logic [7:0] com_on;
    logic [7:0] seg_on;
    assign com_on = com_pins.oe & com_pins.val;
    assign seg_on = seg_pins.oe & seg_pins.val;
    assign lit_row = (com_on != 8'h00) ? seg_on : 8'h00;
    always_comb begin
        lit_com = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (com_on[i]) begin
                lit_com = 4'(i + 1);
            end
        end
    end
    // two lit commons ghost a whole row, so count them
    initial overlap_cnt = 8'h00;
    always @(posedge ref_clk) begin
        if ($countones(com_on) > 1) begin
            overlap_cnt <= overlap_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, scan_hold_option;
    logic [15:0] wb_adr;
    logic [3:0] wb_sel, oscillator_option_code, lit_com;
    logic [31:0] wb_dat_w, wb_dat_r;
    dsc_pkg::dsc_pin8_t seg_pins, com_pins;
    logic [7:0] lcd_com, lcd_com_oe, lit_row, overlap_cnt, v;
    logic [27:0] lcd_seg, lcd_seg_oe, e;
    logic [7:0] ram [28];
    logic [7:0] rd_q [$];
    logic [13:0] regs [5];
    int mismatches, checked, seed, n, nseg;

    dsc_display_scan DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .oscillator_option_code(oscillator_option_code),
        .scan_hold_option(scan_hold_option), .led_segment_output(seg_pins), .led_common_output(com_pins),
        .lcd_common_output(lcd_com), .lcd_common_oe(lcd_com_oe), .lcd_segment_output(lcd_seg),
        .lcd_segment_oe(lcd_seg_oe));
    dsc_led_matrix far_side (.ref_clk(ref_clk), .seg_pins(seg_pins), .com_pins(com_pins),
        .lit_row(lit_row), .lit_com(lit_com), .overlap_cnt(overlap_cnt));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // =========================================
    // bus master, one classic cycle per call
    task automatic wb(input logic we, input logic [13:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hF);
        int k;
        k = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= sel;
        wb_dat_w <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 100);
        if (k >= 100) begin
            chk(32'h0, 32'h1);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, idx, 8'h00);
    endtask

    // read data is judged where ack is sampled
    always @(posedge ref_clk) begin
        if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
            chk(wb_dat_r, {24'h000000, rd_q.pop_front()});
        end
    end

    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end

    initial begin
        seed = 18;
        {sys_rst, wb_cyc, wb_stb, wb_we, scan_hold_option} = 5'b10001;
        {wb_adr, wb_sel, wb_dat_w} = '0;
        oscillator_option_code = 4'h0;
        regs = '{dsc_pkg::IDX_P1_SEL, dsc_pkg::IDX_P2_SEL, dsc_pkg::IDX_P3_SEL, dsc_pkg::IDX_PSC, dsc_pkg::IDX_EXT};
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // =========================================
        // register map
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(dsc_pkg::IDX_CTRL, 8'h00);
        foreach (regs[i]) begin
            v = 8'($random(seed));
            wb(1'b1, regs[i], v);
            rd(regs[i], (regs[i] == dsc_pkg::IDX_PSC) ? (v & dsc_pkg::PSC_MASK) : v);
        end
        wb(1'b1, 14'h0123, 8'hA5);
        rd(14'h0123, 8'h00);
        wb(1'b1, dsc_pkg::IDX_P1_SEL, 8'h3C);
        wb(1'b1, dsc_pkg::IDX_P1_SEL, 8'hC3, 4'hE);
        rd(dsc_pkg::IDX_P1_SEL, 8'h3C);
        for (int i = 0; i < 28; i++) begin
            ram[i] = 8'($random(seed));
            wb(1'b1, dsc_pkg::IDX_RAM_FIRST + 14'(i), ram[i]);
        end
        rd(dsc_pkg::IDX_RAM_LAST, ram[27]);
        // =========================================
        // led scan at 1/8 duty, fastest prescale
        wb(1'b1, dsc_pkg::IDX_P1_SEL, 8'hFF);
        wb(1'b1, dsc_pkg::IDX_P3_SEL, 8'hFF);
        wb(1'b1, dsc_pkg::IDX_PSC, 8'h03);
        wb(1'b1, dsc_pkg::IDX_EXT, 8'h00);
        wb(1'b1, dsc_pkg::IDX_CTRL, 8'h90);
        wb(1'b1, dsc_pkg::IDX_CTRL, 8'hD0);
        repeat (5) @(posedge ref_clk);
        chk(com_pins, 16'hFF01);
        chk(seg_pins, {8'hFF, ram[0]});
        chk(lit_row, ram[0]);
        chk({4'h0, lcd_seg_oe} | {24'h000000, lcd_com_oe}, 32'h0);
        n = 0;
        while (com_pins.val !== 8'h02 && n < 60000) begin
            @(posedge ref_clk);
            n++;
        end
        // slot is 500/8 ticks of 781 clocks, start phase unknown by one tick
        chk(32'(n + 5 >= 61 * 781 && n + 5 <= 63 * 781), 32'h1);
        @(posedge ref_clk);
        chk({lit_com, lit_row}, {4'h2, ram[1]});
        chk(overlap_cnt, 8'h00);
        wb(1'b1, dsc_pkg::IDX_P1_SEL, 8'h0F);
        wb(1'b1, dsc_pkg::IDX_P3_SEL, 8'h02);
        wb(1'b1, dsc_pkg::IDX_P2_SEL, 8'hFF);
        wb(1'b1, dsc_pkg::IDX_MISC_SEL, 8'hFF);
        ram[1] = 8'($random(seed));
        wb(1'b1, dsc_pkg::IDX_RAM_FIRST + 14'h1, ram[1]);
        repeat (3) @(posedge ref_clk);
        chk(seg_pins, {8'h0F, ram[1]});
        chk(com_pins.oe, 8'h02);
        chk(lcd_seg_oe, 28'h0);
        wb(1'b1, dsc_pkg::IDX_EXT, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk({seg_pins.oe, com_pins.oe}, 16'h0);
        rd(dsc_pkg::IDX_STATUS, 8'h51);
        wb(1'b1, dsc_pkg::IDX_EXT, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk({seg_pins.oe, com_pins.val}, 16'h0F02);
        // 1/3 duty keeps common 2 in range
        wb(1'b1, dsc_pkg::IDX_EXT, 8'h20);
        wb(1'b1, dsc_pkg::IDX_CTRL, 8'hC0);
        rd(dsc_pkg::IDX_STATUS, 8'h11);
        wb(1'b1, dsc_pkg::IDX_CTRL, 8'h90);
        repeat (3) @(posedge ref_clk);
        chk({com_pins.val, lit_row}, 16'h0);
        // =========================================
        // glass layouts, every duty code
        wb(1'b1, dsc_pkg::IDX_P1_SEL, 8'hFF);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, dsc_pkg::IDX_EXT, {1'b0, 2'(c >> 1), 5'h00});
            wb(1'b1, dsc_pkg::IDX_CTRL, {3'b010, 1'(c), 4'h0});
            repeat (4) @(posedge ref_clk);
            nseg = (c == 1) ? 24 : (c == 3) ? 27 : (c == 4 || c == 5) ? 26 : 28;
            for (int s = 0; s < 28; s++) e[s] = (s < nseg) ? ram[s][0] : 1'b0;
            chk(lcd_seg, e);
            chk(lcd_seg_oe, (32'h1 << nseg) - 32'h1);
            chk({lcd_com, lcd_com_oe}, 16'h01FF);
            chk({seg_pins.oe, com_pins.val}, 16'h0);
        end
        // reset in mid-run with the led driver on
        wb(1'b1, dsc_pkg::IDX_CTRL, 8'hD0);
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk({com_pins, seg_pins}, 32'h0);
        rd(dsc_pkg::IDX_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk);
        end_sim();
    end
endmodule
`default_nettype wire
